// file: otp_cfg.svh
// otp_cfg.svh - timing counts and constants of the word programmer
// assumes a 50 MHz core clock and a 17-bit word address memory
`ifndef OTP_CFG_SVH
`define OTP_CFG_SVH
`define OTP_CLK_MHZ        50
// program pulse in tenths of a microsecond: nominal 50.0, window 47.5 .. 52.5
`define OTP_PW_NOM_DUS     500
`define OTP_PW_MIN_DUS     475
`define OTP_PW_MAX_DUS     525
`define OTP_PW_CYC         ((`OTP_PW_NOM_DUS * `OTP_CLK_MHZ) / 10)
// setup/hold around strobe and supply settling, microseconds
`define OTP_SETUP_US       2
`define OTP_SETUP_CYC      (`OTP_SETUP_US * `OTP_CLK_MHZ)
// read settle after output enable: 150 ns rounds up to 8 cycles
`define OTP_OE_NS          150
`define OTP_OE_CYC         ((`OTP_OE_NS + 19) / 20)
`define OTP_MAX_RETRY      4'ha
`define OTP_LAST_ADDR      17'h1ffff
`define OTP_ID_MAKER_SEL   1'b0
`define OTP_ID_DEVICE_SEL  1'b1
`endif

// file: otp_pkg.sv
// otp_pkg.sv - types shared by the programmer, its checker and the memory model
// assumes nothing beyond the header of constants
package otp_pkg;
    typedef enum logic [2:0] {
        OTP_SUP_READ,
        OTP_SUP_PROG,
        OTP_SUP_IDENT
    } otp_supply_e;
    typedef logic [16:0] otp_addr_t;
    typedef logic [15:0] otp_word_t;
endpackage : otp_pkg

// file: otp_tmr_if.sv
// otp_tmr_if.sv - start/done carrier between sequencer and timer
// assumes one clock domain
interface otp_tmr_if;
    logic        start;
    logic [15:0] cycles;
    logic        done;
    modport master (output start, output cycles, input done);
    modport timer  (input start, input cycles, output done);
endinterface : otp_tmr_if

// file: otp_tmr.sv
// otp_tmr.sv - down counter producing a one-cycle done pulse
// assumes start is a single-cycle pulse from the sequencer
module otp_tmr (
    // clock and reset
    input  wire logic  core_clk_i,
    input  wire logic  rstn_i,
    // control
    otp_tmr_if.timer   tmr
);
    logic [15:0] cnt_q;
    logic        run_q;

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            cnt_q <= 16'h0000;
            run_q <= 1'b0;
        end else if (tmr.start) begin
            cnt_q <= tmr.cycles;
            run_q <= 1'b1;
        end else if (run_q) begin
            cnt_q <= cnt_q - 16'h0001;
            if (cnt_q == 16'h0001) begin
                run_q <= 1'b0;
            end
        end
    end

    assign tmr.done = run_q && (cnt_q == 16'h0001);
endmodule : otp_tmr

// file: otp_prog.sv
// otp_prog.sv - external programmer sequencing a 128K x 16 OTP memory
// assumes source words arrive through a request/answer port, the supplies
// are switched by outside regulators steered by supply_sel_o, data bus is
// two-way and readback passes two flip-flops before compare.
`include "otp_cfg.svh"
module otp_prog #(
    parameter int unsigned ADDR_W    = 17,
    parameter logic [16:0] LAST_ADDR = `OTP_LAST_ADDR
) (
    // clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  rstn_i,
    // user command port
    input  wire logic                  start_prog_i,
    input  wire logic                  start_id_i,
    input  wire logic                  id_sel_i,
    output logic                       busy_o,
    output logic                       done_o,
    output logic                       fail_o,
    output logic [15:0]                id_word_o,
    // source data request/answer
    output logic                       src_req_o,
    output logic [16:0]                src_addr_o,
    input  wire logic                  src_ack_i,
    input  wire logic [15:0]           src_data_i,
    // memory pins
    output logic [16:0]                addr_o,
    output logic                       id_high_voltage_line_o,
    output logic                       chip_en_n_o,
    output logic                       out_en_n_o,
    output logic                       program_strobe_n_o,
    output logic [15:0]                data_o,
    output logic                       data_oe_o,
    input  wire logic [15:0]           data_i,
    output otp_pkg::otp_supply_e       supply_sel_o
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_SUPPLY, ST_FETCH, ST_SETUP, ST_PULSE, ST_HOLD,
        ST_OE, ST_CMP, ST_NEXT, ST_RD_FETCH, ST_RD_OE, ST_RD_CMP, ST_ID_OE, ST_END
    } otp_state_e;

    otp_state_e          st_q;
    otp_pkg::otp_addr_t  addr_q;
    otp_pkg::otp_word_t  want_q;
    otp_pkg::otp_word_t  dsync1_q;
    otp_pkg::otp_word_t  dsync2_q;
    logic [3:0]          retry_q;
    logic                verify_pass_q;
    logic                id_sel_q;
    logic                tmr_busy_q;
    otp_tmr_if           tif ();

    // 2-flop sync of the memory data pins; only dsync2_q is compared
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            dsync1_q <= 16'h0000;
            dsync2_q <= 16'h0000;
        end else begin
            dsync1_q <= data_i;
            dsync2_q <= dsync1_q;
        end
    end

    otp_tmr u_tmr (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .tmr        (tif.timer)
    );

    function automatic logic [15:0] wait_cycles(input otp_state_e s);
        case (s)
            ST_PULSE: wait_cycles = 16'(`OTP_PW_CYC);
            ST_OE, ST_RD_OE, ST_ID_OE: wait_cycles = 16'(`OTP_OE_CYC + 2);
            default:  wait_cycles = 16'(`OTP_SETUP_CYC);
        endcase
    endfunction : wait_cycles

    // timer is started once on entry to each timed state
    logic timed;
    assign timed = (st_q == ST_SUPPLY) || (st_q == ST_SETUP) || (st_q == ST_PULSE) ||
                   (st_q == ST_HOLD) || (st_q == ST_OE) || (st_q == ST_RD_OE) ||
                   (st_q == ST_ID_OE);
    assign tif.start  = timed && !tmr_busy_q;
    assign tif.cycles = wait_cycles(st_q);

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            tmr_busy_q <= 1'b0;
        end else if (tif.done) begin
            tmr_busy_q <= 1'b0;
        end else if (tif.start) begin
            tmr_busy_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            st_q          <= ST_IDLE;
            addr_q        <= 17'h00000;
            want_q        <= 16'h0000;
            retry_q       <= 4'h0;
            verify_pass_q <= 1'b1;
            id_sel_q      <= 1'b0;
            fail_o        <= 1'b0;
            done_o        <= 1'b0;
            id_word_o     <= 16'h0000;
            supply_sel_o  <= otp_pkg::OTP_SUP_READ;
        end else begin
            done_o <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (start_prog_i) begin
                        addr_q        <= 17'h00000;
                        retry_q       <= 4'h0;
                        fail_o        <= 1'b0;
                        verify_pass_q <= 1'b1;
                        supply_sel_o  <= otp_pkg::OTP_SUP_PROG;
                        st_q          <= ST_SUPPLY;
                    end else if (start_id_i) begin
                        id_sel_q     <= id_sel_i;
                        supply_sel_o <= otp_pkg::OTP_SUP_IDENT;
                        st_q         <= ST_ID_OE;
                    end
                end
                ST_SUPPLY: if (tif.done) st_q <= ST_FETCH;
                ST_FETCH: begin
                    if (src_ack_i) begin
                        want_q <= src_data_i;
                        st_q   <= ST_SETUP;
                    end
                end
                ST_SETUP: if (tif.done) st_q <= ST_PULSE;
                ST_PULSE: if (tif.done) st_q <= ST_HOLD;
                // one unread pulse, then verify
                // a second blind pulse would push the total past 1 + 10
                ST_HOLD: if (tif.done) st_q <= ST_OE;
                ST_OE: if (tif.done) st_q <= ST_CMP;
                ST_CMP: begin
                    if (dsync2_q == want_q) begin
                        st_q <= ST_NEXT;
                    end else if (retry_q == `OTP_MAX_RETRY) begin
                        fail_o <= 1'b1;
                        st_q   <= ST_END;
                    end else begin
                        retry_q <= retry_q + 4'h1;
                        st_q    <= ST_SETUP;
                    end
                end
                ST_NEXT: begin
                    retry_q <= 4'h0;
                    if (addr_q == LAST_ADDR) begin
                        // back to 5 V, reread all
                        supply_sel_o <= otp_pkg::OTP_SUP_READ;
                        addr_q       <= 17'h00000;
                        st_q         <= ST_RD_FETCH;
                    end else begin
                        addr_q <= addr_q + 17'h00001;
                        st_q   <= ST_FETCH;
                    end
                end
                ST_RD_FETCH: begin
                    if (src_ack_i) begin
                        want_q <= src_data_i;
                        st_q   <= ST_RD_OE;
                    end
                end
                ST_RD_OE: if (tif.done) st_q <= ST_RD_CMP;
                ST_RD_CMP: begin
                    if (dsync2_q != want_q) begin
                        verify_pass_q <= 1'b0;
                    end
                    if (addr_q == LAST_ADDR) begin
                        fail_o <= (dsync2_q != want_q) || !verify_pass_q;
                        st_q   <= ST_END;
                    end else begin
                        addr_q <= addr_q + 17'h00001;
                        st_q   <= ST_RD_FETCH;
                    end
                end
                ST_ID_OE: begin
                    if (tif.done) begin
                        id_word_o    <= {8'h00, dsync2_q[7:0]};
                        supply_sel_o <= otp_pkg::OTP_SUP_READ;
                        st_q         <= ST_END;
                    end
                end
                ST_END: begin
                    supply_sel_o <= otp_pkg::OTP_SUP_READ;
                    done_o       <= 1'b1;
                    st_q         <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    logic prog_phase;
    logic read_phase;
    assign prog_phase = (st_q == ST_SETUP) || (st_q == ST_PULSE) || (st_q == ST_HOLD);
    assign read_phase = (st_q == ST_OE) || (st_q == ST_CMP) || (st_q == ST_RD_OE) ||
                        (st_q == ST_RD_CMP) || (st_q == ST_ID_OE);

    assign busy_o     = (st_q != ST_IDLE);
    assign src_req_o  = (st_q == ST_FETCH) || (st_q == ST_RD_FETCH);
    assign src_addr_o = addr_q;
    assign addr_o = (st_q == ST_ID_OE) ? {16'h0000, id_sel_q} : addr_q;
    assign id_high_voltage_line_o = (st_q == ST_ID_OE);
    assign chip_en_n_o        = !(prog_phase || read_phase);
    assign out_en_n_o         = !read_phase;
    assign program_strobe_n_o = !(st_q == ST_PULSE);
    assign data_o             = want_q;
    assign data_oe_o          = prog_phase;
endmodule : otp_prog

// file: otp_prog_chk.sv
// pin assertions for the word programmer
// assumes one clock and a synchronous active-low reset
module otp_prog_chk #(
    parameter logic [16:0] LAST_ADDR = 17'h1ffff
) (
    // clock, reset and status
    input wire logic                 core_clk_i,
    input wire logic                 rstn_i,
    input wire logic                 busy_o,
    input wire logic                 done_o,
    input wire logic                 fail_o,
    input wire logic [15:0]          id_word_o,
    // memory pins
    input wire logic [16:0]          addr_o,
    input wire logic                 id_high_voltage_line_o,
    input wire logic                 chip_en_n_o,
    input wire logic                 out_en_n_o,
    input wire logic                 program_strobe_n_o,
    input wire logic [15:0]          data_o,
    input wire logic                 data_oe_o,
    input wire otp_pkg::otp_supply_e supply_sel_o
);
    logic [15:0] low_cnt_q;
    logic [3:0]  hit_cnt_q;
    logic        first_q;
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i || program_strobe_n_o)
            low_cnt_q <= 16'h0000;
        else
            low_cnt_q <= low_cnt_q + 16'h0001;
    end
    // pulses on one address; a moved address starts a new count
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i || !busy_o || $changed(addr_o))
            hit_cnt_q <= 4'h0;
        else if ($fell(program_strobe_n_o))
            hit_cnt_q <= hit_cnt_q + 4'h1;
    end
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i || $fell(program_strobe_n_o))
            first_q <= 1'b0;
        else if ($rose(busy_o))
            first_q <= 1'b1;
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // 16'h0947 = 2375 and 16'h0a41 = 2625 cycles at 50 MHz
    pulse_width_a: assert property ($rose(program_strobe_n_o) |->
        low_cnt_q >= 16'h0947 && low_cnt_q <= 16'h0a41) else $error("strobe width out of window");
    pulse_stable_a: assert property (!program_strobe_n_o [*2] |->
        $stable(addr_o) && $stable(data_o) && data_oe_o && !chip_en_n_o)
        else $error("address or data moved during strobe");
    pulse_supply_a: assert property (!program_strobe_n_o |->
        supply_sel_o == otp_pkg::OTP_SUP_PROG) else $error("strobe without programming supply");
    first_addr_a: assert property ($fell(program_strobe_n_o) && first_q |->
        addr_o == 17'h00000) else $error("first pulse not at address zero");
    retry_limit_a: assert property (hit_cnt_q <= 4'hb)
        else $error("too many pulses on one address");
    last_addr_a: assert property (!program_strobe_n_o |-> addr_o <= LAST_ADDR)
        else $error("pulse beyond last address");
    end_supply_a: assert property (done_o |-> supply_sel_o == otp_pkg::OTP_SUP_READ)
        else $error("run ended with raised supply");
    id_pins_a: assert property (id_high_voltage_line_o |-> addr_o[16:1] == 16'h0000
        && program_strobe_n_o && !data_oe_o) else $error("identification pins wrong");
    id_enable_a: assert property (id_high_voltage_line_o && !out_en_n_o |-> !chip_en_n_o)
        else $error("identification read without chip enable");
    id_upper_a: assert property (done_o |-> id_word_o[15:8] == 8'h00)
        else $error("identification upper byte not zero");
    cover property (done_o && !fail_o);
    cover property (done_o && fail_o);
    cover property (id_high_voltage_line_o && !out_en_n_o);
endmodule : otp_prog_chk

bind otp_prog otp_prog_chk #(.LAST_ADDR(LAST_ADDR)) chk (.*);

// file: otp_mem_model.sv
// behavioural four-word one-time-programmable memory
// assumes the programmer clock; weak address ignores a number of pulses
module otp_mem_model #(
    parameter logic [7:0] MAKER_CODE  = 8'h5a, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'hc3  // arbitrary value
) (
    // clock and pins
    input  wire logic                 clk_i,
    input  wire logic [16:0]          addr_i,
    input  wire logic                 id_hv_i,
    input  wire logic                 chip_en_n_i,
    input  wire logic                 out_en_n_i,
    input  wire logic                 strobe_n_i,
    input  wire logic [15:0]          data_i,
    input  wire otp_pkg::otp_supply_e supply_i,
    // fault control
    input  wire logic [16:0]          weak_addr_i,
    input  wire logic [4:0]           weak_pulses_i,
    // read data
    output logic [15:0]               data_o
);
    logic [15:0] mem [4];
    logic [4:0]  hits = 5'h00;
    logic        strobe_q = 1'b1;
    initial begin
        foreach (mem[i]) mem[i] = 16'hffff;
        data_o = 16'h0000;
    end
    always @(posedge clk_i) begin
        strobe_q <= strobe_n_i;
        if (supply_i == otp_pkg::OTP_SUP_READ)
            hits <= 5'h00;
        else if (!strobe_n_i && strobe_q && !chip_en_n_i && supply_i == otp_pkg::OTP_SUP_PROG) begin
            if (addr_i == weak_addr_i && hits < weak_pulses_i)
                hits <= hits + 5'h01;
            else
                mem[addr_i[1:0]] <= data_i;
        end
    end
    always @(posedge clk_i) begin
        if (!chip_en_n_i && !out_en_n_i)
            data_o <= id_hv_i ? {8'h00, addr_i[0] ? DEVICE_CODE : MAKER_CODE} : mem[addr_i[1:0]];
        else
            data_o <= ~data_o;
    end
endmodule : otp_mem_model

// file: otp_word_program_sequencer_bench.sv
// self-checking bench of the word programmer
// assumes otp_prog, its timer, checker and memory model compiled first
module otp_word_program_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MAKER = 8'h5a;  // arbitrary value
    localparam logic [7:0] DEVICE = 8'hc3; // arbitrary value
    logic core_clk_i = 1'b0, rstn_i = 1'b0, start_prog_i = 1'b0, start_id_i = 1'b0;
    logic id_sel_i = 1'b0, src_ack_i = 1'b0;
    logic busy_o, done_o, fail_o, src_req_o, id_hv, ce_n, oe_n, strobe_n, data_oe;
    logic [15:0] src_data_i = 16'h0000, id_word_o, data_o, mdl_data, data_i;
    logic [16:0] src_addr_o, addr_o, weak_addr = 17'h00002;
    logic [4:0]  weak_pulses = 5'h03;
    logic [17:0] note;
    logic [17:0] exp_q [$];
    logic [15:0] src [4];
    otp_pkg::otp_supply_e supply;
    int num_errors = 0, cmp_count = 0, cycles = 0, seed = 65;
    always #10 core_clk_i = ~core_clk_i;
    assign data_i = data_oe ? data_o : mdl_data;
    otp_prog #(.LAST_ADDR(17'h00003)) uut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .start_prog_i(start_prog_i), .start_id_i(start_id_i), .id_sel_i(id_sel_i),
        .busy_o(busy_o), .done_o(done_o), .fail_o(fail_o), .id_word_o(id_word_o),
        .src_req_o(src_req_o), .src_addr_o(src_addr_o), .src_ack_i(src_ack_i),
        .src_data_i(src_data_i), .addr_o(addr_o), .id_high_voltage_line_o(id_hv),
        .chip_en_n_o(ce_n), .out_en_n_o(oe_n), .program_strobe_n_o(strobe_n),
        .data_o(data_o), .data_oe_o(data_oe), .data_i(data_i), .supply_sel_o(supply));
    otp_mem_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) mdl (.clk_i(core_clk_i),
        .addr_i(addr_o), .id_hv_i(id_hv), .chip_en_n_i(ce_n), .out_en_n_i(oe_n),
        .strobe_n_i(strobe_n), .data_i(data_o), .supply_i(supply), .weak_addr_i(weak_addr),
        .weak_pulses_i(weak_pulses), .data_o(mdl_data));
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // source answers one cycle late; data toggles while not valid
    always @(posedge core_clk_i) begin
        src_ack_i <= src_req_o && !src_ack_i;
        src_data_i <= (src_req_o && !src_ack_i) ? src[src_addr_o[1:0]] : ~src_data_i;
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            num_errors++;
            final_report();
        end
    end
    always @(negedge core_clk_i) begin
        if (rstn_i && done_o === 1'b1) begin
            if (exp_q.size() == 0)
                check("done count", 16'h0000, 16'h0001);
            else begin
                note = exp_q.pop_front();
                if (note[17])
                    check("id word", note[15:0], id_word_o);
                else
                    check("fail flag", {15'h0000, note[16]}, {15'h0000, fail_o});
            end
        end
    end
    // a start while busy must leave no trace
    task automatic run(input string name, input logic is_id, input logic sel,
                       input logic exp_fail, input logic [15:0] exp_word, input logic poke);
        exp_q.push_back({is_id, exp_fail, exp_word});
        @(posedge core_clk_i);
        start_prog_i <= !is_id;
        start_id_i <= is_id;
        id_sel_i <= sel;
        @(posedge core_clk_i);
        start_prog_i <= 1'b0;
        start_id_i <= 1'b0;
        if (poke) begin
            repeat (50) @(posedge core_clk_i);
            start_id_i <= 1'b1;
            @(posedge core_clk_i);
            start_id_i <= 1'b0;
        end
        @(negedge core_clk_i);
        while (busy_o !== 1'b0) @(negedge core_clk_i);
        repeat (3) @(negedge core_clk_i);
        $display("test %s finished", name);
    endtask : run
    initial begin
        foreach (src[i]) src[i] = 16'($random(seed));
        repeat (5) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        for (int s = 0; s < 2; s++)
            run("identification", 1'b1, s[0], 1'b0, {8'h00, s[0] ? DEVICE : MAKER}, 1'b0);
        run("program with retries", 1'b0, 1'b0, 1'b0, 16'h0000, 1'b1);
        foreach (src[i]) check("stored word", src[i], mdl.mem[i]);
        foreach (src[i]) src[i] = ~src[i];
        weak_addr = 17'h00000;
        weak_pulses = 5'h14;
        run("program stuck word", 1'b0, 1'b0, 1'b1, 16'h0000, 1'b0);
        check("pending results", 16'h0000, 16'(exp_q.size()));
        final_report();
    end
endmodule : otp_word_program_sequencer_bench
